// ==== hw/tdm_chan_defines.svh ====
// constants for the subscriber bus channel data registers
// assumes byte addresses on a 32-bit AXI4-Lite bus, 96-bit frames
`ifndef TDM_CHAN_DEFINES_SVH
`define TDM_CHAN_DEFINES_SVH

// register byte addresses
`define ADDR_BUS_ACCESS 32'hF013000C
`define ADDR_IC_TX 32'hF0130010
`define ADDR_IC_RX 32'hF0130014
`define ADDR_CMD0_TX 32'hF0130018
`define ADDR_CMD0_RX 32'hF013001C
`define ADDR_CMD1_TX 32'hF0130020
`define ADDR_CMD1_RX 32'hF0130024
`define ADDR_MON_TX 32'hF0130028
`define ADDR_LINK_CTRL 32'hF0130040

// field widths
`define IC_W 8
`define CMD0_W 4
`define CMD1_W 6
`define MON_W 8
`define BAA_W 3

// reset values
`define RST_IC_TX 8'hFF
`define RST_CMD0_TX 4'hF
`define RST_CMD1_TX 6'h3F
`define RST_MON_TX 8'hFF
`define RST_BUS_ACCESS 3'h7

// link control register fields
`define CTRL_MON_EN_BIT 0
`define CTRL_MON_SEL_LSB 1
`define CTRL_WON_BIT 8

// frame layout: bit numbers from frame start, fields sent msb first
`define FRAME_BITS 7'h60
`define FRAME_LAST 7'h5F
`define CH_BITS 7'h20
`define MON_START 7'h10
`define CMD0_START 7'h1A
`define IC_START 7'h20
`define CMD1_START 7'h38
`define ARB_START 7'h5B

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hw/tdm_chan_pkg.sv ====
// types for the subscriber bus channel data registers
// assumes field widths agree with tdm_chan_defines.svh
package tdm_chan_pkg;

   // software settings of the link side
   typedef struct packed {
      logic monitor_enable;
      logic [1:0] monitor_select;
      logic [2:0] bus_access_address;
   } link_ctrl_t;

   // write channel states
   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESP = 2'b10
   } wr_state_t;

   // read channel states
   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } rd_state_t;

endpackage

// ==== hw/tdm_double_look.sv ====
// accepts a received code only after two equal frames in a row
// assumes i_frame_done is a one-cycle pulse with i_code stable
`timescale 1ns/1ps
module tdm_double_look #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // frame input
   input wire logic i_frame_done,
   input wire logic [W-1:0] i_code,
   // accepted code
   output logic [W-1:0] o_code
);
   logic [W-1:0] prev;
   logic prev_valid;
   logic [W-1:0] code;
   logic [W-1:0] next_prev;
   logic next_prev_valid;
   logic [W-1:0] next_code;

   // compare with last frame
   always_comb begin
      next_prev = prev;
      next_prev_valid = prev_valid;
      next_code = code;
      if (i_frame_done) begin
         next_prev = i_code;
         next_prev_valid = 1'b1;
         if (prev_valid && (i_code == prev)) begin
            next_code = i_code;
         end
      end
   end

   // registers
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         prev <= '0;
         prev_valid <= 1'b0;
         code <= '0;
      end else begin
         prev <= next_prev;
         prev_valid <= next_prev_valid;
         code <= next_code;
      end
   end

   assign o_code = code;
endmodule

// ==== hw/tdm_subscriber_bus_channel_regs.sv ====
// channel data registers of a tdm subscriber bus port, axi4-lite slave
// assumes the link clock, frame sync and data come from another domain
//
// Function
// - intercom tx byte, resets ones, sent
// - intercom rx byte readable, resets zero
// - cmd0 tx code repeated every frame while the bus access is won
// - cmd0 rx updates after two equal frames
// - cmd1 tx code repeated every frame
// - cmd1 rx updates after two equal frames
// - monitor byte on selected channel when enabled
// - bus access address arbitrates d/cmd0
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "tdm_chan_defines.svh"
module tdm_subscriber_bus_channel_regs (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // axi4-lite write
   input wire logic [31:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // axi4-lite read
   input wire logic [31:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // link pins
   input wire logic i_link_clk,
   input wire logic i_link_sync,
   input wire logic i_link_din,
   output logic o_link_dout,
   output logic o_link_dout_oe_n
);
   // register state
   tdm_chan_pkg::wr_state_t wr_state, next_wr_state;
   tdm_chan_pkg::rd_state_t rd_state, next_rd_state;
   tdm_chan_pkg::link_ctrl_t ctrl, next_ctrl;
   logic aw_got, next_aw_got;
   logic w_got, next_w_got;
   logic [31:0] awaddr_q, next_awaddr_q;
   logic [31:0] wdata_q, next_wdata_q;
   logic wstrb0_q, next_wstrb0_q;
   logic [1:0] bresp, next_bresp;
   logic [31:0] rdata, next_rdata;
   logic [1:0] rresp, next_rresp;
   logic [7:0] ic_tx, next_ic_tx;
   logic [3:0] cmd0_tx, next_cmd0_tx;
   logic [5:0] cmd1_tx, next_cmd1_tx;
   logic [7:0] mon_tx, next_mon_tx;
   // link state
   logic [1:0] clk_sync, din_sync, fs_sync;
   logic clk_prev;
   logic [6:0] bit_cnt, next_bit_cnt;
   logic [95:0] rx_frame, next_rx_frame;
   logic dout, next_dout;
   logic dout_oe_n, next_dout_oe_n;
   logic lost, next_lost;
   logic won, next_won;
   logic frame_done, next_frame_done;
   logic [7:0] ic_rx, next_ic_rx;
   // accepted codes
   logic [3:0] cmd0_rx;
   logic [5:0] cmd1_rx;
   // helpers
   logic rise, fall;
   logic [6:0] cur;
   logic [6:0] arb_off;
   logic [95:0] tx_frame, tx_mask;
   logic [31:0] rd_word;
   logic rd_hit;
   logic wr_hit;

   // read mux, upper bits zero
   always_comb begin
      rd_word = 32'h0;
      rd_hit = 1'b1;
      case (i_araddr)
         `ADDR_IC_TX: rd_word[7:0] = ic_tx;
         `ADDR_IC_RX: rd_word[7:0] = ic_rx;
         `ADDR_CMD0_TX: rd_word[3:0] = cmd0_tx;
         `ADDR_CMD0_RX: rd_word[3:0] = cmd0_rx;
         `ADDR_CMD1_TX: rd_word[5:0] = cmd1_tx;
         `ADDR_CMD1_RX: rd_word[5:0] = cmd1_rx;
         `ADDR_MON_TX: rd_word[7:0] = mon_tx;
         `ADDR_BUS_ACCESS: rd_word[2:0] = ctrl.bus_access_address;
         `ADDR_LINK_CTRL: begin
            rd_word[`CTRL_MON_EN_BIT] = ctrl.monitor_enable;
            rd_word[`CTRL_MON_SEL_LSB +: 2] = ctrl.monitor_select;
            rd_word[`CTRL_WON_BIT] = won;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // write channel and writable registers
   always_comb begin
      next_wr_state = wr_state;
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_awaddr_q = awaddr_q;
      next_wdata_q = wdata_q;
      next_wstrb0_q = wstrb0_q;
      next_bresp = bresp;
      next_ctrl = ctrl;
      next_ic_tx = ic_tx;
      next_cmd0_tx = cmd0_tx;
      next_cmd1_tx = cmd1_tx;
      next_mon_tx = mon_tx;
      wr_hit = 1'b0;
      case (wr_state)
         tdm_chan_pkg::WR_COLLECT: begin
            if (i_awvalid && !aw_got) begin
               next_aw_got = 1'b1;
               next_awaddr_q = i_awaddr;
            end
            if (i_wvalid && !w_got) begin
               next_w_got = 1'b1;
               next_wdata_q = i_wdata;
               next_wstrb0_q = i_wstrb[0];
            end
            if (next_aw_got && next_w_got) begin
               wr_hit = 1'b1;
               case (next_awaddr_q)
                  `ADDR_IC_TX: begin
                     if (next_wstrb0_q) next_ic_tx = next_wdata_q[7:0];
                  end
                  `ADDR_CMD0_TX: begin
                     if (next_wstrb0_q) next_cmd0_tx = next_wdata_q[3:0];
                  end
                  `ADDR_CMD1_TX: begin
                     if (next_wstrb0_q) next_cmd1_tx = next_wdata_q[5:0];
                  end
                  `ADDR_MON_TX: begin
                     if (next_wstrb0_q) next_mon_tx = next_wdata_q[7:0];
                  end
                  `ADDR_BUS_ACCESS: begin
                     if (next_wstrb0_q) next_ctrl.bus_access_address = next_wdata_q[2:0];
                  end
                  `ADDR_LINK_CTRL: begin
                     if (next_wstrb0_q) begin
                        next_ctrl.monitor_enable = next_wdata_q[`CTRL_MON_EN_BIT];
                        next_ctrl.monitor_select = next_wdata_q[`CTRL_MON_SEL_LSB +: 2];
                     end
                  end
                  `ADDR_IC_RX, `ADDR_CMD0_RX, `ADDR_CMD1_RX: wr_hit = 1'b1;
                  default: wr_hit = 1'b0;
               endcase
               next_bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
               next_aw_got = 1'b0;
               next_w_got = 1'b0;
               next_wr_state = tdm_chan_pkg::WR_RESP;
            end
         end
         tdm_chan_pkg::WR_RESP: begin
            if (i_bready) next_wr_state = tdm_chan_pkg::WR_COLLECT;
         end
         default: next_wr_state = tdm_chan_pkg::WR_COLLECT;
      endcase
   end

   // read channel
   always_comb begin
      next_rd_state = rd_state;
      next_rdata = rdata;
      next_rresp = rresp;
      case (rd_state)
         tdm_chan_pkg::RD_IDLE: begin
            if (i_arvalid) begin
               next_rdata = rd_word;
               next_rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
               next_rd_state = tdm_chan_pkg::RD_RESP;
            end
         end
         tdm_chan_pkg::RD_RESP: begin
            if (i_rready) next_rd_state = tdm_chan_pkg::RD_IDLE;
         end
         default: next_rd_state = tdm_chan_pkg::RD_IDLE;
      endcase
   end

   // bus registers
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_state <= tdm_chan_pkg::WR_COLLECT;
         rd_state <= tdm_chan_pkg::RD_IDLE;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         awaddr_q <= 32'h0;
         wdata_q <= 32'h0;
         wstrb0_q <= 1'b0;
         bresp <= `RESP_OKAY;
         rdata <= 32'h0;
         rresp <= `RESP_OKAY;
         ctrl <= '{monitor_enable: 1'b0, monitor_select: 2'h0,
                   bus_access_address: `RST_BUS_ACCESS};
         ic_tx <= `RST_IC_TX;
         cmd0_tx <= `RST_CMD0_TX;
         cmd1_tx <= `RST_CMD1_TX;
         mon_tx <= `RST_MON_TX;
      end else begin
         wr_state <= next_wr_state;
         rd_state <= next_rd_state;
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         awaddr_q <= next_awaddr_q;
         wdata_q <= next_wdata_q;
         wstrb0_q <= next_wstrb0_q;
         bresp <= next_bresp;
         rdata <= next_rdata;
         rresp <= next_rresp;
         ctrl <= next_ctrl;
         ic_tx <= next_ic_tx;
         cmd0_tx <= next_cmd0_tx;
         cmd1_tx <= next_cmd1_tx;
         mon_tx <= next_mon_tx;
      end
   end

   // bus handshake outputs
   assign o_awready = (wr_state == tdm_chan_pkg::WR_COLLECT) && !aw_got;
   assign o_wready = (wr_state == tdm_chan_pkg::WR_COLLECT) && !w_got;
   assign o_bvalid = (wr_state == tdm_chan_pkg::WR_RESP);
   assign o_bresp = bresp;
   assign o_arready = (rd_state == tdm_chan_pkg::RD_IDLE);
   assign o_rvalid = (rd_state == tdm_chan_pkg::RD_RESP);
   assign o_rdata = rdata;
   assign o_rresp = rresp;

   // transmit frame image, msb of each field first on the wire
   always_comb begin
      tx_frame = 96'h0;
      tx_mask = 96'h0;
      tx_frame[`FRAME_LAST - `IC_START -: 8] = ic_tx;
      tx_mask[`FRAME_LAST - `IC_START -: 8] = 8'hFF;
      tx_frame[`FRAME_LAST - `CMD0_START -: 4] = cmd0_tx;
      tx_mask[`FRAME_LAST - `CMD0_START -: 4] = {4{won}};
      tx_frame[`FRAME_LAST - `CMD1_START -: 6] = cmd1_tx;
      tx_mask[`FRAME_LAST - `CMD1_START -: 6] = 6'h3F;
      case (ctrl.monitor_select)
         2'h0: begin
            tx_frame[`FRAME_LAST - `MON_START -: 8] = mon_tx;
            tx_mask[`FRAME_LAST - `MON_START -: 8] = {8{ctrl.monitor_enable}};
         end
         2'h1: begin
            tx_frame[`FRAME_LAST - `MON_START - `CH_BITS -: 8] = mon_tx;
            tx_mask[`FRAME_LAST - `MON_START - `CH_BITS -: 8] = {8{ctrl.monitor_enable}};
         end
         2'h2: begin
            tx_frame[`FRAME_LAST - `MON_START - 2 * `CH_BITS -: 8] = mon_tx;
            tx_mask[`FRAME_LAST - `MON_START - 2 * `CH_BITS -: 8] =
               {8{ctrl.monitor_enable}};
         end
         default: ;
      endcase
      // address bits, zeros pulled low only
      tx_mask[`FRAME_LAST - `ARB_START -: 3] = ~ctrl.bus_access_address & {3{!lost}};
   end

   // link edge detection on the synchronised clock
   assign rise = clk_sync[1] && !clk_prev;
   assign fall = !clk_sync[1] && clk_prev;
   assign cur = (rise && fs_sync[1]) ? 7'h0 : bit_cnt;
   assign arb_off = 7'(bit_cnt - `ARB_START);

   // bit counter, drive on rising edge, sample on falling edge
   always_comb begin
      next_bit_cnt = bit_cnt;
      next_rx_frame = rx_frame;
      next_dout = dout;
      next_dout_oe_n = dout_oe_n;
      next_lost = lost;
      next_won = won;
      next_frame_done = 1'b0;
      next_ic_rx = ic_rx;
      if (rise) begin
         next_bit_cnt = cur;
         if (cur < `FRAME_BITS) begin
            next_dout = tx_frame[7'(`FRAME_LAST - cur)];
            next_dout_oe_n = !tx_mask[7'(`FRAME_LAST - cur)];
         end else begin
            next_dout = 1'b1;
            next_dout_oe_n = 1'b1;
         end
         if (fs_sync[1]) next_lost = 1'b0;
      end else if (fall && (bit_cnt < `FRAME_BITS)) begin
         next_rx_frame[7'(`FRAME_LAST - bit_cnt)] = din_sync[1];
         // lose on a zero over our one
         if ((bit_cnt >= `ARB_START) && (arb_off < 7'h3) &&
             ctrl.bus_access_address[2'(7'h2 - arb_off)] && !din_sync[1]) begin
            next_lost = 1'b1;
         end
         next_bit_cnt = 7'(bit_cnt + 7'h1);
         if (bit_cnt == `FRAME_LAST) begin
            next_frame_done = 1'b1;
            next_won = !next_lost;
         end
      end
      if (frame_done) next_ic_rx = rx_frame[`FRAME_LAST - `IC_START -: 8];
   end

   // link registers, the first sync stage feeds only the second
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         clk_sync <= 2'h0;
         din_sync <= 2'h3;
         fs_sync <= 2'h0;
         clk_prev <= 1'b0;
         bit_cnt <= `FRAME_BITS;
         rx_frame <= 96'h0;
         dout <= 1'b1;
         dout_oe_n <= 1'b1;
         lost <= 1'b0;
         won <= 1'b0;
         frame_done <= 1'b0;
         ic_rx <= 8'h0;
      end else begin
         clk_sync <= {clk_sync[0], i_link_clk};
         din_sync <= {din_sync[0], i_link_din};
         fs_sync <= {fs_sync[0], i_link_sync};
         clk_prev <= clk_sync[1];
         bit_cnt <= next_bit_cnt;
         rx_frame <= next_rx_frame;
         dout <= next_dout;
         dout_oe_n <= next_dout_oe_n;
         lost <= next_lost;
         won <= next_won;
         frame_done <= next_frame_done;
         ic_rx <= next_ic_rx;
      end
   end

   assign o_link_dout = dout;
   assign o_link_dout_oe_n = dout_oe_n;

   tdm_double_look #(.W(`CMD0_W)) cmd0_look (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_frame_done(frame_done),
      .i_code(rx_frame[`FRAME_LAST - `CMD0_START -: 4]),
      .o_code(cmd0_rx)
   );

   tdm_double_look #(.W(`CMD1_W)) cmd1_look (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_frame_done(frame_done),
      .i_code(rx_frame[`FRAME_LAST - `CMD1_START -: 6]),
      .o_code(cmd1_rx)
   );
endmodule

// ==== verif/tdm_chan_regs_chk.sv ====
// checker for the channel register block: bus handshakes, read data, link timing
// assumes one clock domain and the top module's port names
`timescale 1ns/1ps
module tdm_chan_regs_chk (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // bus handshakes
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] o_rresp,
   input wire logic o_rvalid,
   input wire logic i_rready,
   // link
   input wire logic i_link_clk,
   input wire logic o_link_dout
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   // response holds until taken
   wr_resp_hold_a: assert property (
      o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped early");
   rd_resp_hold_a: assert property (
      o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read response dropped early");
   // no new request while a response waits
   wr_busy_a: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write ready during response");
   rd_busy_a: assert property (o_rvalid |-> !o_arready)
      else $error("read ready during response");
   // answers one cycle after the handshake
   rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   wr_answer_a: assert property (
      i_awvalid && o_awready && i_wvalid && o_wready |=> o_bvalid)
      else $error("write answer late");
   // reserved bits read zero, errors carry no data
   rd_upper_a: assert property (
      o_rvalid && o_rresp == 2'h0 |-> o_rdata[31:9] == 23'h0)
      else $error("reserved read bits set");
   rd_err_a: assert property (
      o_rvalid && o_rresp != 2'h0 |-> o_rresp == 2'h2 && o_rdata == 32'h0)
      else $error("bad error response");
   // transmit bit moves only shortly after a link rising edge
   link_dout_a: assert property (
      $changed(o_link_dout) |-> $past(i_link_clk, 2) && !$past(i_link_clk, 6))
      else $error("transmit bit changed off link edge");
endmodule

bind tdm_subscriber_bus_channel_regs tdm_chan_regs_chk i_tdm_chan_regs_chk (.*);

// ==== verif/tdm_line_model.sv ====
// line transceiver model: drives link clock, frame sync and receive data
// assumes 96-bit frames, link clock low and still between frames
`timescale 1ns/1ps
module tdm_line_model (
   // from the block
   input wire logic i_dout,
   input wire logic i_dout_oe_n,
   // to the block
   output logic o_link_clk,
   output logic o_link_sync,
   output logic o_link_din
);
   // idle line levels
   initial begin
      o_link_clk = 1'b0;
      o_link_sync = 1'b0;
      o_link_din = 1'b1;
   end
   // one frame, bit 0 first; transmit bit taken at the end of each bit
   task automatic send_frame(input logic [95:0] tx, output logic [95:0] seen,
                             output logic [95:0] oe_n);
      for (int b = 0; b < 96; b++) begin
         o_link_din <= tx[95-b];
         o_link_sync <= (b == 0);
         o_link_clk <= 1'b1;
         #40;
         o_link_clk <= 1'b0;
         #39;
         seen[95-b] = i_dout;
         oe_n[95-b] = i_dout_oe_n;
         #1;
      end
      o_link_sync <= 1'b0;
      // released line floats back up to its pull-up level
      o_link_din <= 1'b1;
   endtask
endmodule

// ==== verif/tdm_subscriber_bus_channel_regs_bench.sv ====
// bench for the channel register block: bus tasks, frames and checks
// assumes the line model supplies link clock, sync and receive data
`timescale 1ns/1ps
`include "tdm_chan_defines.svh"
module tdm_subscriber_bus_channel_regs_bench;
   logic i_clk_sys, i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, ga, gw, gb;
   logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata, d;
   logic [3:0] i_wstrb;
   logic [1:0] o_bresp, o_rresp, r;
   logic i_link_clk, i_link_sync, i_link_din, o_link_dout, o_link_dout_oe_n;
   logic [95:0] seen, oen, fv;
   int mismatches, n_checks;

   tdm_subscriber_bus_channel_regs i_tdm_subscriber_bus_channel_regs (.*);
   tdm_line_model i_tdm_line_model (.i_dout(o_link_dout), .i_dout_oe_n(o_link_dout_oe_n),
      .o_link_clk(i_link_clk), .o_link_sync(i_link_sync), .o_link_din(i_link_din));

   // system clock
   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // write: address and data together, bready held until the answer
   task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
      i_awaddr <= a;
      i_wdata <= v;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      for (int t = 0; t < 40; t++) begin
         @(negedge i_clk_sys);
         ga = i_awvalid && o_awready;
         gw = i_wvalid && o_wready;
         gb = o_bvalid;
         rs = o_bresp;
         @(posedge i_clk_sys);
         if (ga) i_awvalid <= 1'b0;
         if (gw) i_wvalid <= 1'b0;
         if (gb) begin
            i_bready <= 1'b0;
            @(posedge i_clk_sys); // one edge between two requests
            return;
         end
      end
      mismatches++;
      close_out();
   endtask

   // read: rready held until the answer
   task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      for (int t = 0; t < 40; t++) begin
         @(negedge i_clk_sys);
         ga = i_arvalid && o_arready;
         gb = o_rvalid;
         v = o_rdata;
         rs = o_rresp;
         @(posedge i_clk_sys);
         if (ga) i_arvalid <= 1'b0;
         if (gb) begin
            i_rready <= 1'b0;
            @(posedge i_clk_sys); // one edge between two requests
            return;
         end
      end
      mismatches++;
      close_out();
   endtask

   task automatic t_reset;
      logic [31:0] adr [9];
      logic [31:0] rst [9];
      adr = '{`ADDR_IC_TX, `ADDR_IC_RX, `ADDR_CMD0_TX, `ADDR_CMD0_RX, `ADDR_CMD1_TX,
              `ADDR_CMD1_RX, `ADDR_MON_TX, `ADDR_BUS_ACCESS, `ADDR_LINK_CTRL};
      rst = '{32'hFF, 32'h0, 32'hF, 32'h0, 32'h3F, 32'h0, 32'hFF, 32'h7, 32'h0};
      for (int k = 0; k < 9; k++) begin
         rd(adr[k], d, r);
         chk("reset value", rst[k], d);
      end
      $display("test reset values done");
   endtask

   task automatic t_unmapped;
      wr(32'hF0130030, 32'hFFFFFFFF, r);
      chk("unmapped write resp", 32'h2, {30'h0, r});
      rd(32'hF0130030, d, r);
      chk("unmapped read resp", 32'h2, {30'h0, r});
      chk("unmapped read data", 32'h0, d);
      wr(`ADDR_IC_RX, 32'hAA, r);
      rd(`ADDR_IC_RX, d, r);
      chk("rx write ignored", 32'h0, d);
      wr(`ADDR_IC_TX, 32'hFFFFFF5A, r);
      rd(`ADDR_IC_TX, d, r);
      chk("reserved bits", 32'h5A, d);
      // low byte lane off: answered, but the byte stays
      i_wstrb <= 4'hE;
      wr(`ADDR_IC_TX, 32'h11, r);
      i_wstrb <= 4'hF;
      rd(`ADDR_IC_TX, d, r);
      chk("masked write", 32'h5A, d);
      $display("test unmapped and reserved done");
   endtask

   // one frame, then the three receive registers
   task automatic frame(input logic [31:0] c0, input logic [31:0] c1);
      i_tdm_line_model.send_frame(fv, seen, oen);
      repeat (10) @(posedge i_clk_sys);
      rd(`ADDR_IC_RX, d, r);
      chk("intercom rx", 32'h96, d);
      rd(`ADDR_CMD0_RX, d, r);
      chk("cmd0 rx", c0, d);
      rd(`ADDR_CMD1_RX, d, r);
      chk("cmd1 rx", c1, d);
   endtask

   task automatic t_frames;
      wr(`ADDR_CMD0_TX, 32'hC, r);
      wr(`ADDR_CMD1_TX, 32'h15, r);
      wr(`ADDR_MON_TX, 32'h3C, r);
      wr(`ADDR_LINK_CTRL, 32'h3, r);
      fv = {96{1'b1}};
      fv[95-`IC_START -: 8] = 8'h96;
      fv[95-`CMD0_START -: 4] = 4'h9;
      fv[95-`CMD1_START -: 6] = 6'h2A;
      frame(32'h0, 32'h0);
      chk("intercom tx", 32'h5A, 32'(seen[95-`IC_START -: 8]));
      chk("cmd1 tx", 32'h15, 32'(seen[95-`CMD1_START -: 6]));
      chk("monitor tx", 32'h3C, 32'(seen[95-48 -: 8]));
      chk("monitor drive", 32'h0, 32'(oen[95-48 -: 8]));
      chk("cmd0 held off", 32'hF, 32'(oen[95-`CMD0_START -: 4]));
      frame(32'h9, 32'h2A);
      chk("cmd0 tx", 32'hC, 32'(seen[95-`CMD0_START -: 4]));
      wr(`ADDR_BUS_ACCESS, 32'h5, r);
      wr(`ADDR_LINK_CTRL, 32'h0, r);
      fv[95-`CMD0_START -: 4] = 4'h3;
      frame(32'h9, 32'h2A);
      chk("cmd0 tx repeat", 32'hC, 32'(seen[95-`CMD0_START -: 4]));
      chk("monitor off", 32'hFF, 32'(oen[95-16 -: 8]));
      chk("access address", 32'h5, 32'(oen[95-`ARB_START -: 3]));
      rd(`ADDR_LINK_CTRL, d, r);
      chk("access won", 32'h100, d);
      // a zero on the wire over our first one bit loses the access
      fv[95-`ARB_START -: 3] = 3'h3;
      frame(32'h3, 32'h2A);
      chk("cmd0 driven", 32'h0, 32'(oen[95-`CMD0_START -: 4]));
      chk("access lost", 32'h7, 32'(oen[95-`ARB_START -: 3]));
      rd(`ADDR_LINK_CTRL, d, r);
      chk("access not won", 32'h0, d);
      $display("test frames done");
   endtask

   // hang guard, well beyond four frames
   initial begin
      #200000;
      mismatches++;
      close_out();
   end

   initial begin
      i_reset_n = 1'b0;
      i_awvalid = 1'b0;
      i_wvalid = 1'b0;
      i_bready = 1'b0;
      i_arvalid = 1'b0;
      i_rready = 1'b0;
      i_awaddr = 32'h0;
      i_wdata = 32'h0;
      i_araddr = 32'h0;
      i_wstrb = 4'hF;
      mismatches = 0;
      n_checks = 0;
      repeat (6) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      @(posedge i_clk_sys);
      t_reset();
      t_unmapped();
      t_frames();
      close_out();
   end
endmodule
